/* design/ccp_consts.vh */
// Constants for the charge counter host port
`ifndef CCP_CONSTS_VH
`define CCP_CONSTS_VH
// Register map
`define CCP_ADDR_OFFSET      7'h73
`define CCP_ADDR_TEMPCLR     7'h74
`define CCP_ADDR_MODE        7'h75
`define CCP_ADDR_CT_LO       7'h76
`define CCP_ADDR_CT_HI       7'h77
`define CCP_ADDR_DT_LO       7'h78
`define CCP_ADDR_DT_HI       7'h79
`define CCP_ADDR_SD_LO       7'h7A
`define CCP_ADDR_SD_HI       7'h7B
`define CCP_ADDR_CC_LO       7'h7C
`define CCP_ADDR_CC_HI       7'h7D
`define CCP_ADDR_DC_LO       7'h7E
`define CCP_ADDR_DC_HI       7'h7F
`define CCP_DEDICATED_COUNT  13
// Command fields
`define CCP_CMD_WRITE_BIT    7
// Mode register fields
`define CCP_MODE_OVR_BIT     7
`define CCP_MODE_CAL_BIT     6
`define CCP_MODE_STC_BIT     5
`define CCP_MODE_STD_BIT     4
`define CCP_MODE_RESET       8'h0E
`define CCP_MODE_WR_MASK     8'hCE
// Clear bits in temperature/clear register
`define CCP_CLR_CT_BIT       4
`define CCP_CLR_DT_BIT       3
`define CCP_CLR_SD_BIT       2
`define CCP_CLR_CC_BIT       1
`define CCP_CLR_DC_BIT       0
// Temperature band code for 20 to 30 C, the unit-rate band
`define CCP_TEMP_UNIT_CODE   3'h3
// Clock and link timing
`define CCP_CLK_HZ           40000000
`define CCP_BIT_START_US     60
`define CCP_BIT_SAMPLE_US    100
`define CCP_BIT_CYCLE_US     200
`define CCP_BREAK_US         190
`define CCP_BREAK_REC_US     40
`define CCP_RESP_US          190
`define CCP_BIT_START_CYC    ((`CCP_BIT_START_US * (`CCP_CLK_HZ / 1000000)))
`define CCP_BIT_SAMPLE_CYC   ((`CCP_BIT_SAMPLE_US * (`CCP_CLK_HZ / 1000000)))
`define CCP_BIT_CYCLE_CYC    ((`CCP_BIT_CYCLE_US * (`CCP_CLK_HZ / 1000000)))
`define CCP_BREAK_CYC        ((`CCP_BREAK_US * (`CCP_CLK_HZ / 1000000)))
`define CCP_BREAK_REC_CYC    ((`CCP_BREAK_REC_US * (`CCP_CLK_HZ / 1000000)))
`define CCP_RESP_CYC         ((`CCP_RESP_US * (`CCP_CLK_HZ / 1000000)))
// Calibration timing, in seconds; cycles built in the top module
`define CCP_CAL_ARM_S        10
`define CCP_CAL_RUN_S        3600
// Default time-count tick 0.8789 s, slow tick 225 s
`define CCP_TICK_FAST_US     878900
`define CCP_TICK_SLOW_US     225000000
// Self-discharge base tick (x1/16 of an hour is the x16 band)
`define CCP_SD_BASE_S        225
`define CCP_FIFO_DEPTH       8
`endif

/* design/ccp_fifo.v */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ccp_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             core_clk,
   input  wire             rst_n,
   input  wire             clkEn,
   // Fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // Drain side
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wrPtr_ff;
   reg [AW-1:0]    rdPtr_ff;
   reg [AW:0]      count_ff;
   wire            doWr;
   wire            doRd;

   assign inReady  = (count_ff != DEPTH[AW:0]);
   assign outValid = (count_ff != {(AW+1){1'b0}});
   assign outData  = mem[rdPtr_ff];
   assign doWr     = clkEn & inValid & inReady;
   assign doRd     = clkEn & outValid & outReady;

   always @(posedge core_clk) begin
      if (doWr) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_ff <= {AW{1'b0}};
         rdPtr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
      end else begin
         if (doWr) begin
            wrPtr_ff <= wrPtr_ff + 1'b1;
         end
         if (doRd) begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
         end
         if (doWr & ~doRd) begin
            count_ff <= count_ff + 1'b1;
         end else if (doRd & ~doWr) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule // ccp_fifo
`default_nettype wire

/* design/ccp_host_port.v */
// Host port of the charge counter: single-wire link, register map, calibration
`timescale 1ns/100ps
`default_nettype none
`include "ccp_consts.vh"
module ccp_host_port #(
   parameter CAL_ARM_CYC  = `CCP_CAL_ARM_S * `CCP_CLK_HZ,
   parameter CAL_RUN_CYC  = 64'd144000000000,
   parameter TICK_FAST_CYC = 35156000,
   parameter TICK_SLOW_CYC = 64'd9000000000,
   parameter SD_BASE_CYC  = 64'd9000000000,
   // Link timing in clock cycles; a bench may shorten these to keep runs brief
   parameter BIT_START    = `CCP_BIT_START_CYC,
   parameter BIT_SAMPLE   = `CCP_BIT_SAMPLE_CYC,
   parameter BIT_CYCLE    = `CCP_BIT_CYCLE_CYC,
   parameter BRK_CYC      = `CCP_BREAK_CYC,
   parameter BRK_REC      = `CCP_BREAK_REC_CYC,
   parameter RESP_CYC     = `CCP_RESP_CYC
) (
   // Clock, reset, enable
   input  wire       core_clk,
   input  wire       rst_n,
   input  wire       clkEn,
   // Single-wire line (open drain)
   input  wire       lineIn,
   output wire       lineOut,
   output wire       lineOe,
   // Measurement front end
   input  wire       chargeEvent,
   input  wire       dischargeEvent,
   input  wire       isCharging,
   input  wire       isDischarging,
   input  wire [2:0] tempCode,
   input  wire       senseBelowWake,
   input  wire [7:0] measuredOffset,
   // Status
   output wire       lowPower,
   output wire [2:0] wakeThreshold
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_RECV = 5'h02;
   localparam [4:0] ST_WAIT = 5'h04;
   localparam [4:0] ST_SEND = 5'h08;
   localparam [4:0] ST_BRK  = 5'h10;
   localparam [3:0] CAL_OFF  = 4'h1;
   localparam [3:0] CAL_ARM  = 4'h2;
   localparam [3:0] CAL_RUN  = 4'h4;
   localparam [3:0] CAL_DONE = 4'h8;
   localparam integer GP_TOP_I  = 127 - `CCP_DEDICATED_COUNT;
   localparam [6:0]  GP_TOP     = GP_TOP_I[6:0];

   reg [7:0]  gpMem [0:GP_TOP];
   reg [4:0]  st_ff;
   reg [15:0] tmr_ff;
   reg [15:0] lowCnt_ff;
   reg        lineQ_ff;
   reg [2:0]  bitCnt_ff;
   reg [7:0]  shift_ff;
   reg        haveCmd_ff;
   reg [7:0]  cmd_ff;
   reg        driveLow_ff;
   reg        ready_ff;
   reg [7:0]  offset_ff;
   reg [7:0]  mode_ff;
   reg [4:0]  clr_ff;
   reg [15:0] dc_ff;
   reg [15:0] cc_ff;
   reg [15:0] sd_ff;
   reg [15:0] dt_ff;
   reg [15:0] ct_ff;
   reg [63:0] dtTick_ff;
   reg [63:0] ctTick_ff;
   reg [63:0] sdTick_ff;
   reg [63:0] calCnt_ff;
   reg [3:0]  cal_ff;
   reg [7:0]  rdData;
   wire       fall = lineQ_ff & ~lineIn;
   wire       fifoValid;
   wire [7:0] fifoData;
   wire       fifoReady;
   wire       popByte;
   wire [6:0] addr = cmd_ff[6:0];
   wire       byteDone = (st_ff == ST_RECV) && tmr_ff == BIT_SAMPLE && bitCnt_ff == 3'd7;
   wire [7:0] rxByte = {lineIn, shift_ff[7:1]};
   wire       wrStrobe = clkEn && byteDone && haveCmd_ff && cmd_ff[`CCP_CMD_WRITE_BIT];
   wire       cmdLoad  = clkEn && byteDone && !haveCmd_ff;
   wire       lineOk = lineIn == 1'b0 || mode_ff[`CCP_MODE_OVR_BIT];
   wire [63:0] sdPeriod = SD_BASE_CYC << (3'd7 - tempCode);

   assign lineOut       = 1'b0;
   assign lineOe        = driveLow_ff;
   assign lowPower      = (cal_ff == CAL_DONE);
   assign wakeThreshold = mode_ff[3:1];

   // Read data goes through the FIFO; the sender pops it once the response delay RESP_CYC has run
   ccp_fifo #(.WIDTH(8), .DEPTH(`CCP_FIFO_DEPTH), .AW(3)) uFifo (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .inValid  (cmdLoad && !rxByte[`CCP_CMD_WRITE_BIT]),
      .inReady  (fifoReady),
      .inData   (rdData),
      .outValid (fifoValid),
      .outReady (popByte),
      .outData  (fifoData)
   );
   assign popByte = (st_ff == ST_WAIT) && tmr_ff == RESP_CYC;

   always @* begin
      case (rxByte[6:0])
         `CCP_ADDR_OFFSET:  rdData = offset_ff;
         `CCP_ADDR_TEMPCLR: rdData = {tempCode, clr_ff};
         `CCP_ADDR_MODE:    rdData = {mode_ff[7:1], 1'b0};
         `CCP_ADDR_CT_LO:   rdData = ct_ff[7:0];
         `CCP_ADDR_CT_HI:   rdData = ct_ff[15:8];
         `CCP_ADDR_DT_LO:   rdData = dt_ff[7:0];
         `CCP_ADDR_DT_HI:   rdData = dt_ff[15:8];
         `CCP_ADDR_SD_LO:   rdData = sd_ff[7:0];
         `CCP_ADDR_SD_HI:   rdData = sd_ff[15:8];
         `CCP_ADDR_CC_LO:   rdData = cc_ff[7:0];
         `CCP_ADDR_CC_HI:   rdData = cc_ff[15:8];
         `CCP_ADDR_DC_LO:   rdData = dc_ff[7:0];
         `CCP_ADDR_DC_HI:   rdData = dc_ff[15:8];
         default:           rdData = gpMem[rxByte[6:0]];
      endcase
   end

   always @(posedge core_clk) begin
      if (wrStrobe && addr <= GP_TOP) begin
         gpMem[addr] <= rxByte;
      end
   end

   // Link engine: receive, respond, break detection
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff       <= ST_BRK;
         tmr_ff      <= 16'h0000;
         lowCnt_ff   <= 16'h0000;
         lineQ_ff    <= 1'b1;
         bitCnt_ff   <= 3'h0;
         shift_ff    <= 8'h00;
         haveCmd_ff  <= 1'b0;
         cmd_ff      <= 8'h00;
         driveLow_ff <= 1'b0;
         ready_ff    <= 1'b0;
      end else if (clkEn) begin
         lineQ_ff <= lineIn;
         lowCnt_ff <= lineIn ? 16'h0000 : (lowCnt_ff == BRK_CYC ? lowCnt_ff : lowCnt_ff + 1'b1);
         if (!lineIn && lowCnt_ff == BRK_CYC - 1'b1 && st_ff != ST_SEND) begin
            st_ff      <= ST_BRK;
            // Restart framing so a stray start edge cannot shift the next command
            bitCnt_ff  <= 3'h0;
            tmr_ff     <= 16'h0000;
            haveCmd_ff <= 1'b0;
            ready_ff   <= 1'b0;
         end else begin
            case (st_ff)
               ST_BRK: begin
                  tmr_ff <= lineIn ? tmr_ff + 1'b1 : 16'h0000;
                  if (lineIn && tmr_ff == BRK_REC) begin
                     st_ff    <= ST_IDLE;
                     ready_ff <= 1'b1;
                  end
               end
               ST_IDLE: begin
                  if (fall && ready_ff) begin
                     st_ff  <= ST_RECV;
                     tmr_ff <= 16'h0001;
                  end
               end
               ST_RECV: begin
                  tmr_ff <= tmr_ff + 1'b1;
                  if (tmr_ff == BIT_SAMPLE) begin
                     shift_ff  <= rxByte;
                     bitCnt_ff <= bitCnt_ff + 1'b1;
                     st_ff     <= ST_IDLE;
                     if (byteDone) begin
                        if (!haveCmd_ff) begin
                           cmd_ff     <= rxByte;
                           haveCmd_ff <= rxByte[`CCP_CMD_WRITE_BIT];
                           if (!rxByte[`CCP_CMD_WRITE_BIT]) begin
                              st_ff  <= ST_WAIT;
                              tmr_ff <= 16'h0000;
                           end
                        end else begin
                           haveCmd_ff <= 1'b0;
                        end
                     end
                  end
               end
               ST_WAIT: begin
                  tmr_ff <= tmr_ff + 1'b1;
                  if (popByte) begin
                     shift_ff  <= fifoData;
                     bitCnt_ff <= 3'h0;
                     tmr_ff    <= 16'h0000;
                     st_ff     <= ST_SEND;
                  end
               end
               ST_SEND: begin
                  tmr_ff <= tmr_ff + 1'b1;
                  if (tmr_ff == 16'h0000) begin
                     driveLow_ff <= 1'b1;
                  end else if (tmr_ff == BIT_START) begin
                     driveLow_ff <= ~shift_ff[0];
                  end else if (tmr_ff == BIT_SAMPLE + BIT_START) begin
                     driveLow_ff <= 1'b0;
                  end else if (tmr_ff == BIT_CYCLE) begin
                     tmr_ff    <= 16'h0000;
                     shift_ff  <= {1'b0, shift_ff[7:1]};
                     bitCnt_ff <= bitCnt_ff + 1'b1;
                     if (bitCnt_ff == 3'd7) begin
                        st_ff <= ST_IDLE;
                     end
                  end
               end
               default: st_ff <= ST_BRK;
            endcase
         end
      end
   end

   // Counters, clear bits, mode register and calibration
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         offset_ff <= 8'h00;
         mode_ff   <= `CCP_MODE_RESET;
         clr_ff    <= 5'h00;
         dc_ff     <= 16'h0000;
         cc_ff     <= 16'h0000;
         sd_ff     <= 16'h0000;
         dt_ff     <= 16'h0000;
         ct_ff     <= 16'h0000;
         dtTick_ff <= 64'h0;
         ctTick_ff <= 64'h0;
         sdTick_ff <= 64'h0;
         calCnt_ff <= 64'h0;
         cal_ff    <= CAL_OFF;
      end else if (clkEn) begin
         // Clears take one cycle; a write in the same cycle overrides the self-clear of clr_ff
         clr_ff <= 5'h00;
         if (wrStrobe && addr == `CCP_ADDR_TEMPCLR) begin
            clr_ff <= rxByte[4:0];
         end
         if (wrStrobe && addr == `CCP_ADDR_OFFSET) begin
            offset_ff <= rxByte;
         end
         if (wrStrobe && addr == `CCP_ADDR_MODE) begin
            // Zero threshold is refused; keep the previous field
            mode_ff <= (rxByte & `CCP_MODE_WR_MASK) | (mode_ff & ~`CCP_MODE_WR_MASK);
            if (rxByte[3:1] == 3'h0) begin
               mode_ff[3:1] <= mode_ff[3:1];
            end
         end
         if (!lowPower) begin
            if (chargeEvent) begin
               cc_ff <= cc_ff + 1'b1;
            end
            if (dischargeEvent) begin
               dc_ff <= dc_ff + 1'b1;
            end
            sdTick_ff <= (sdTick_ff >= sdPeriod - 1'b1) ? 64'h0 : sdTick_ff + 1'b1;
            if (sdTick_ff >= sdPeriod - 1'b1) begin
               sd_ff <= sd_ff + 1'b1;
            end
            if (isDischarging) begin
               if (dtTick_ff >= (mode_ff[`CCP_MODE_STD_BIT] ? TICK_SLOW_CYC : TICK_FAST_CYC) - 1) begin
                  dtTick_ff <= 64'h0;
                  dt_ff <= dt_ff + 1'b1;
                  if (dt_ff == 16'hFFFF) begin
                     mode_ff[`CCP_MODE_STD_BIT] <= ~mode_ff[`CCP_MODE_STD_BIT];
                  end
               end else begin
                  dtTick_ff <= dtTick_ff + 1'b1;
               end
            end
            if (isCharging) begin
               if (ctTick_ff >= (mode_ff[`CCP_MODE_STC_BIT] ? TICK_SLOW_CYC : TICK_FAST_CYC) - 1) begin
                  ctTick_ff <= 64'h0;
                  ct_ff <= ct_ff + 1'b1;
                  if (ct_ff == 16'hFFFF) begin
                     mode_ff[`CCP_MODE_STC_BIT] <= ~mode_ff[`CCP_MODE_STC_BIT];
                  end
               end else begin
                  ctTick_ff <= ctTick_ff + 1'b1;
               end
            end
         end
         if (clr_ff[`CCP_CLR_DC_BIT]) begin
            dc_ff <= 16'h0000;
         end
         if (clr_ff[`CCP_CLR_CC_BIT]) begin
            cc_ff <= 16'h0000;
         end
         if (clr_ff[`CCP_CLR_SD_BIT]) begin
            sd_ff <= 16'h0000;
         end
         if (clr_ff[`CCP_CLR_DT_BIT]) begin
            dt_ff <= 16'h0000;
            dtTick_ff <= 64'h0;
            mode_ff[`CCP_MODE_STD_BIT] <= 1'b0;
         end
         if (clr_ff[`CCP_CLR_CT_BIT]) begin
            ct_ff <= 16'h0000;
            ctTick_ff <= 64'h0;
            mode_ff[`CCP_MODE_STC_BIT] <= 1'b0;
         end
         case (cal_ff)
            CAL_OFF: begin
               calCnt_ff <= 64'h0;
               if (mode_ff[`CCP_MODE_CAL_BIT] && lineOk && senseBelowWake) begin
                  cal_ff <= CAL_ARM;
               end
            end
            CAL_ARM: begin
               calCnt_ff <= calCnt_ff + 1'b1;
               if (!lineOk || !senseBelowWake || !mode_ff[`CCP_MODE_CAL_BIT]) begin
                  cal_ff <= CAL_OFF;
               end else if (calCnt_ff >= CAL_ARM_CYC) begin
                  cal_ff    <= CAL_RUN;
                  calCnt_ff <= 64'h0;
               end
            end
            CAL_RUN: begin
               calCnt_ff <= calCnt_ff + 1'b1;
               if (!lineOk || !senseBelowWake) begin
                  cal_ff <= CAL_OFF;
               end else if (calCnt_ff >= CAL_RUN_CYC - 1) begin
                  offset_ff <= measuredOffset;
                  mode_ff[`CCP_MODE_CAL_BIT] <= 1'b0;
                  mode_ff[`CCP_MODE_OVR_BIT] <= 1'b0;
                  cal_ff <= CAL_DONE;
               end
            end
            CAL_DONE: begin
               if (lineIn) begin
                  cal_ff <= CAL_OFF;
               end
            end
            default: cal_ff <= CAL_OFF;
         endcase
      end
   end
endmodule // ccp_host_port
`default_nettype wire

/* testbench/ccp_host_port_properties.sv */
// Port-level checker for the charge counter host port
`timescale 1ns/100ps
`default_nettype none
`include "ccp_consts.vh"
module ccp_host_port_properties #(
   parameter int START_CYC    = `CCP_BIT_START_CYC,
   parameter int DATA_END_CYC = `CCP_BIT_START_CYC + `CCP_BIT_SAMPLE_CYC,
   parameter int CYCLE_CYC    = `CCP_BIT_CYCLE_CYC
) (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       rst_n,
   // Single-wire line
   input wire logic       lineIn,
   input wire logic       lineOut,
   input wire logic       lineOe,
   // Calibration and status
   input wire logic       senseBelowWake,
   input wire logic       lowPower,
   input wire logic [2:0] wakeThreshold
);
   logic [13:0] oeCnt;
   logic [13:0] gapCnt;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Pull time and bit spacing counters; gap saturates so the first bit passes
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         oeCnt <= 14'h0000;
         gapCnt <= 14'h3FFF;
      end else begin
         oeCnt <= lineOe ? oeCnt + 14'h0001 : 14'h0000;
         if (lineOe && oeCnt == 14'h0000) begin
            gapCnt <= 14'h0000;
         end else if (gapCnt != 14'h3FFF) begin
            gapCnt <= gapCnt + 14'h0001;
         end
      end
   end
   chk_thresh_valid: assert property (wakeThreshold != 3'h0)
      else $error("wake threshold field is zero");
   chk_thresh_reset: assert property ($rose(rst_n) |-> wakeThreshold == 3'h7)
      else $error("wake threshold not all ones after reset");
   chk_bit_width: assert property ($fell(lineOe) |-> oeCnt inside
         {[START_CYC-3:START_CYC+3], [DATA_END_CYC-3:DATA_END_CYC+3]})
      else $error("reply bit low time wrong");
   chk_pull_bound: assert property (lineOe |-> oeCnt < DATA_END_CYC + 10)
      else $error("line held low beyond a bit frame");
   chk_bit_rate: assert property ((lineOe && oeCnt == 14'h0000) |-> gapCnt >= CYCLE_CYC)
      else $error("reply bits closer than one bit period");
   chk_start_idle: assert property ($rose(lineOe) |-> $past(lineIn))
      else $error("reply bit started on a low line");
   chk_open_drain: assert property (lineOut == 1'b0)
      else $error("line data not held low");
   chk_lp_quiet: assert property (lowPower |-> !lineOe)
      else $error("line pulled while in low power");
   chk_lp_exit: assert property (lowPower && lineIn |-> ##[0:4] !lowPower)
      else $error("low power kept with line high");
   chk_lp_entry: assert property ($rose(lowPower) |-> $past(senseBelowWake))
      else $error("calibration completed with loud sense");
   cover property ($rose(lowPower));
   cover property ($fell(lineOe) && oeCnt > DATA_END_CYC - 10);
   cover property ($fell(lineOe) && oeCnt < START_CYC + 10);
endmodule // ccp_host_port_properties
bind ccp_host_port ccp_host_port_properties #(.START_CYC(BIT_START),
   .DATA_END_CYC(BIT_START + BIT_SAMPLE), .CYCLE_CYC(BIT_CYCLE)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .lineIn(lineIn), .lineOut(lineOut),
   .lineOe(lineOe), .senseBelowWake(senseBelowWake), .lowPower(lowPower),
   .wakeThreshold(wakeThreshold)
);
`default_nettype wire

/* testbench/ccp_host_model.sv */
// Host side of the single-wire link
`timescale 1ns/100ps
`default_nettype none
module ccp_host_model (
   // Clock
   input  wire logic core_clk,
   // Resolved line and host pull
   input  wire logic lineWire,
   output var  logic hostLow
);
   initial hostLow = 1'b0;
   task automatic hold(input logic lvl, input int n);
      hostLow <= lvl;
      repeat (n) @(posedge core_clk);
   endtask
   // Timing follows the bench's shortened link: 400-cycle bit, sample at 200
   task automatic sendBit(input logic b);
      hold(1'b1, b ? 120 : 320);
      hold(1'b0, b ? 280 : 80);
   endtask
   task automatic sendByte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         sendBit(v[i]);
      end
   endtask
   task automatic sendBreak;
      hold(1'b1, 400);
      hold(1'b0, 100);
   endtask
   // Missing reply bits come back unknown so the compare fails
   task automatic recvByte(output logic [7:0] v);
      int t;
      for (int i = 0; i < 8; i++) begin
         t = 0;
         while (lineWire && t < 1000) begin
            @(posedge core_clk);
            t++;
         end
         repeat (200) @(posedge core_clk);
         v[i] = (t < 1000) ? lineWire : 1'bx;
         repeat (150) @(posedge core_clk);
      end
   endtask
endmodule // ccp_host_model
`default_nettype wire

/* testbench/test_coulomb_counter_host_port.sv */
// Self-checking bench for the charge counter host port
`timescale 1ns/100ps
`default_nettype none
module test_coulomb_counter_host_port;
   logic       core_clk, rst_n, clkEn, chargeEvent, dischargeEvent;
   logic       isCharging, isDischarging, senseBelowWake;
   logic [2:0] tempCode;
   logic [7:0] measuredOffset;
   wire        lineWire, lineOut, lineOe, lowPower, hostLow;
   wire  [2:0] wakeThreshold;
   int         error_cnt = 0;
   int         n_checks = 0;
   int         cycles = 0;
   // Pull-up on the line; either party pulls it low
   assign lineWire = !(hostLow || lineOe);
   // Link timing shortened twentyfold to keep the run brief; host model matches
   ccp_host_port #(.CAL_ARM_CYC(200), .CAL_RUN_CYC(1000), .TICK_FAST_CYC(1000),
      .TICK_SLOW_CYC(1000), .SD_BASE_CYC(1000), .BIT_START(120), .BIT_SAMPLE(200),
      .BIT_CYCLE(400), .BRK_CYC(380), .BRK_REC(80), .RESP_CYC(380)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .lineIn(lineWire),
      .lineOut(lineOut), .lineOe(lineOe), .chargeEvent(chargeEvent),
      .dischargeEvent(dischargeEvent), .isCharging(isCharging),
      .isDischarging(isDischarging), .tempCode(tempCode),
      .senseBelowWake(senseBelowWake), .measuredOffset(measuredOffset),
      .lowPower(lowPower), .wakeThreshold(wakeThreshold));
   ccp_host_model host (.core_clk(core_clk), .lineWire(lineWire), .hostLow(hostLow));
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.sendByte({1'b1, a});
      host.sendByte(d);
      repeat (100) @(posedge core_clk);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.sendByte({1'b0, a});
      host.recvByte(v);
      check(v, exp);
      repeat (150) @(posedge core_clk);
   endtask
   task automatic testResetMap;
      host.sendBreak();
      rd(7'h75, 8'h0E);
      check({5'h00, wakeThreshold}, 8'h07);
      $display("testResetMap done");
   endtask
   task automatic testStorage;
      wr(7'h10, 8'hA5);
      rd(7'h10, 8'hA5);
      $display("testStorage done");
   endtask
   task automatic testCounter;
      repeat (3) begin
         chargeEvent <= 1'b1;
         @(posedge core_clk);
         chargeEvent <= 1'b0;
         @(posedge core_clk);
      end
      wr(7'h7C, 8'hFF);
      rd(7'h7C, 8'h03);
      wr(7'h74, 8'h02);
      rd(7'h74, 8'hA0);
      rd(7'h7C, 8'h00);
      $display("testCounter done");
   endtask
   task automatic testCalibration;
      int t;
      wr(7'h75, 8'h40);
      check({5'h00, wakeThreshold}, 8'h07);
      senseBelowWake <= 1'b1;
      measuredOffset <= 8'h5A;
      t = 0;
      while (!lowPower && t < 5000) begin
         host.hold(1'b1, 1);
         t++;
      end
      check({7'h00, lowPower}, 8'h01);
      host.hold(1'b1, 500);
      check({7'h00, lowPower}, 8'h01);
      host.hold(1'b0, 10);
      check({7'h00, lowPower}, 8'h00);
      senseBelowWake <= 1'b0;
      host.hold(1'b0, 100);
      rd(7'h73, 8'h5A);
      rd(7'h75, 8'h0E);
      $display("testCalibration done");
   endtask
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Each transaction spans about 7k cycles; the whole run about 75k
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 100000) begin
         error_cnt++;
         $display("Timeout after %0d cycles", cycles);
         conclude();
      end
   end
   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      chargeEvent = 1'b0;
      dischargeEvent = 1'b0;
      isCharging = 1'b0;
      isDischarging = 1'b0;
      senseBelowWake = 1'b0;
      tempCode = 3'h5;
      measuredOffset = 8'h00;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      testResetMap();
      testStorage();
      testCounter();
      testCalibration();
      conclude();
   end
endmodule // test_coulomb_counter_host_port
`default_nettype wire
